// ==== shared/scie_defines.svh ====
// Bit positions, buffer sizes and reset values for the card port irq logic.
`ifndef SCIE_DEFINES_SVH
`define SCIE_DEFINES_SVH
`define SCIE_EN_TIMER0 3
`define SCIE_EN_TERR 2
`define SCIE_EN_TXE 1
`define SCIE_EN_RXLVL 0
`define SCIE_ST_RX_BUFFER_OVERFLOW_FLAG 0
`define SCIE_ST_PARITY 4
`define SCIE_ST_FRAME 5
`define SCIE_ST_BREAK 6
`define SCIE_ST_TX_BUFFER_OVERFLOW_FLAG 8
`define SCIE_ST_RXRETRY 22
`define SCIE_ST_TXRETRY 30
`define SCIE_CTL_TRG_HI 7
`define SCIE_CTL_TRG_LO 6
`define SCIE_EN_RESET 4'h0
`define SCIE_FLAGS_RESET 4'h2
`define SCIE_RX_DEPTH 4
`define SCIE_CNT_W 3
`endif

// ==== shared/scie_pkg.sv ====
// Types shared by the card port interrupt enable logic.
package scie_pkg;
  // Event inputs from the receiver, transmitter and timer.
  typedef struct packed {
    logic timer0_event;
    logic tx_empty;
    logic rx_timeout_event;
    logic rx_read;
    logic [2:0] rx_count;
  } scie_events_t;
  // Individual transfer error status flags.
  typedef struct packed {
    logic rx_break_error_flag;
    logic frame_error_flag;
    logic parity_error_flag;
    logic rx_buffer_overflow_flag;
    logic tx_buffer_overflow_flag;
    logic rx_retry_over_limit_flag;
    logic tx_retry_over_limit_flag;
  } scie_errors_t;
  // Receive trigger level encodings.
  typedef enum logic [1:0] {
    SCIE_TRG_1 = 2'b00,
    SCIE_TRG_2 = 2'b01,
    SCIE_TRG_3 = 2'b10,
    SCIE_TRG_R = 2'b11
  } scie_trg_t;
endpackage : scie_pkg

// ==== hw/scie_gate.sv ====
// One flag, enable pair feeding the interrupt OR.
`timescale 1ns/1ns
module scie_gate (
  // Flag and its enable.
  input wire logic flag,
  input wire logic enable,
  // Gated request.
  output logic req
);
  // The request passes only while enabled.
  assign req = flag & enable;
endmodule : scie_gate

// ==== hw/scie_irq.sv ====
// Low enable bits of the card port interrupt controller.
// Operation
// R1 - Enable bit 3 lets timer 0 events raise the interrupt only when set.
// R2 - Enable bit 2 lets transfer errors raise the interrupt only when set.
// R3 - Break, frame and parity errors (status 6, 5, 4) are transfer errors.
// R4 - Rx overflow, tx overflow and both retry limits are transfer errors.
// R5 - Enable bit 1 lets an empty transmit buffer raise the interrupt.
// R6 - Enable bit 0 gates the rx count reaching the trigger level in ctl 7:6.
// R7 - The rx timeout flag is read only and clears when the buffer drains.
// R8 - The request is the OR of every set flag whose enable is set.
`timescale 1ns/1ns
`include "scie_defines.svh"
module scie_irq (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Software controls.
  input wire logic [3:0] irq_enable,
  input wire logic [1:0] rx_trigger_level,
  input wire logic [3:0] flag_clear,
  // Event sources.
  input wire scie_pkg::scie_events_t events,
  input wire scie_pkg::scie_errors_t errors,
  // Status and request.
  output logic [31:0] card_port_status_reg,
  output logic [3:0] irq_flags,
  output logic rx_timeout_flag,
  output logic irq
);
  import scie_pkg::*;

  // Flags reset as one word; the tx empty flag starts high.
  localparam logic [3:0] FLAGS_RST = `SCIE_FLAGS_RESET;

  // Registers and their next values.
  logic [3:0] en_q;
  logic tmr_fl_q;
  logic tmr_fl_d;
  logic terr_fl_q;
  logic terr_fl_d;
  logic txe_fl_q;
  logic rxl_fl_q;
  logic [3:0] flag_vec;
  logic tmo_q;
  logic terr;
  logic rx_hit;
  logic [2:0] level;
  logic [3:0] req;
  logic [31:0] stat_d;
  logic irq_q;

  //////////////////////////////////////////////////////////////////////////
  // Enable register captured from software.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_q <= `SCIE_EN_RESET;
    end else if (clk_en) begin
      en_q <= irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer error sources combined into one event.
  assign terr = errors.rx_break_error_flag | errors.frame_error_flag |
                errors.parity_error_flag | // [R3]
                errors.rx_buffer_overflow_flag |
                errors.tx_buffer_overflow_flag |
                errors.rx_retry_over_limit_flag |
                errors.tx_retry_over_limit_flag; // [R4]

  // Trigger level decode; the reserved code behaves as one byte.
  always_comb begin
    case (scie_trg_t'(rx_trigger_level))
      SCIE_TRG_2: level = 3'h2;
      SCIE_TRG_3: level = 3'h3;
      default: level = 3'h1;
    endcase
  end
  assign rx_hit = events.rx_count >= level; // [R6]

  //////////////////////////////////////////////////////////////////////////
  // Timer 0 flag next value; a new event wins over a clear in one cycle.
  always_comb begin
    tmr_fl_d = tmr_fl_q & ~flag_clear[`SCIE_EN_TIMER0];
    if (events.timer0_event) begin
      tmr_fl_d = 1'b1; // [R1]
    end
  end

  // Timer 0 flag register; it stays set until software clears it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tmr_fl_q <= FLAGS_RST[`SCIE_EN_TIMER0];
    end else if (clk_en) begin
      tmr_fl_q <= tmr_fl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer error flag next value; a new error wins over a clear too.
  always_comb begin
    terr_fl_d = terr_fl_q & ~flag_clear[`SCIE_EN_TERR];
    if (terr) begin
      terr_fl_d = 1'b1; // [R2]
    end
  end

  // Transfer error flag register; an error source that stays high keeps
  // setting it, so software must remove the cause before clearing.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      terr_fl_q <= FLAGS_RST[`SCIE_EN_TERR];
    end else if (clk_en) begin
      terr_fl_q <= terr_fl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tx empty flag follows the buffer state one cycle late; no clear needed.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txe_fl_q <= FLAGS_RST[`SCIE_EN_TXE];
    end else if (clk_en) begin
      txe_fl_q <= events.tx_empty; // [R5]
    end
  end

  // Rx level flag follows the count against the trigger level.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxl_fl_q <= FLAGS_RST[`SCIE_EN_RXLVL];
    end else if (clk_en) begin
      rxl_fl_q <= rx_hit; // [R6]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags gathered into one word at their enable bit positions.
  // The vector is wiring only, so irq_flags still comes straight from flops.
  always_comb begin
    flag_vec = 4'h0;
    flag_vec[`SCIE_EN_TIMER0] = tmr_fl_q;
    flag_vec[`SCIE_EN_TERR] = terr_fl_q;
    flag_vec[`SCIE_EN_TXE] = txe_fl_q;
    flag_vec[`SCIE_EN_RXLVL] = rxl_fl_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Timeout flag sets on timeout, clears once the rx buffer is empty.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tmo_q <= 1'b0;
    end else if (clk_en) begin
      if (events.rx_timeout_event && events.rx_count != 3'h0) begin
        tmo_q <= 1'b1;
      end else if (events.rx_count == 3'h0) begin
        tmo_q <= 1'b0; // [R7]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-source gating; a masked flag still shows in irq_flags, so software
  // can poll a source it has chosen not to take interrupts from.
  scie_gate u_g_tmr0 (
    .flag(flag_vec[`SCIE_EN_TIMER0]),
    .enable(en_q[`SCIE_EN_TIMER0]),
    .req(req[3])
  ); // [R1]
  scie_gate u_g_terr (
    .flag(flag_vec[`SCIE_EN_TERR]),
    .enable(en_q[`SCIE_EN_TERR]),
    .req(req[2])
  ); // [R2]
  scie_gate u_g_txe (
    .flag(flag_vec[`SCIE_EN_TXE]),
    .enable(en_q[`SCIE_EN_TXE]),
    .req(req[1])
  ); // [R5]
  scie_gate u_g_rx (
    .flag(flag_vec[`SCIE_EN_RXLVL]),
    .enable(en_q[`SCIE_EN_RXLVL]),
    .req(req[0])
  ); // [R6]

  // Status word with error bits at their positions.
  always_comb begin
    stat_d = 32'h0000_0000;
    stat_d[`SCIE_ST_BREAK] = errors.rx_break_error_flag;
    stat_d[`SCIE_ST_FRAME] = errors.frame_error_flag;
    stat_d[`SCIE_ST_PARITY] = errors.parity_error_flag;
    stat_d[`SCIE_ST_RX_BUFFER_OVERFLOW_FLAG] = errors.rx_buffer_overflow_flag;
    stat_d[`SCIE_ST_TX_BUFFER_OVERFLOW_FLAG] = errors.tx_buffer_overflow_flag;
    stat_d[`SCIE_ST_RXRETRY] = errors.rx_retry_over_limit_flag;
    stat_d[`SCIE_ST_TXRETRY] = errors.tx_retry_over_limit_flag;
  end

  //////////////////////////////////////////////////////////////////////////
  // Request register; it lags the flags by one edge, so a source that is
  // cleared still shows on the pin for one more cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |req; // [R8]
    end
  end

  // Status word register; a pass-through of the error inputs.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      card_port_status_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      card_port_status_reg <= stat_d; // [R3] [R4]
    end
  end

  // Outputs straight from their registers.
  assign irq = irq_q;
  assign irq_flags = flag_vec;
  assign rx_timeout_flag = tmo_q;
endmodule : scie_irq

// ==== dv/scie_sw_model.sv ====
// Software model that answers the request by clearing sticky flags.
`timescale 1ns/1ns
module scie_sw_model (
  // Clock and answer speed.
  input wire logic clock,
  input wire logic slow,
  // Request and flags seen.
  input wire logic irq,
  input wire logic [3:0] irq_flags,
  // Write-one-clear strobes.
  output logic [3:0] flag_clear
);
  // Waits one or four cycles, then clears the sticky flags for one cycle.
  initial begin
    flag_clear = 4'h0;
    forever begin
      @(posedge clock);
      if (irq) begin
        repeat (slow ? 4 : 1) @(posedge clock);
        #1 flag_clear = {irq_flags[3:2], 2'h0};
        @(posedge clock);
        #1 flag_clear = 4'h0;
      end
    end
  end
endmodule : scie_sw_model

// ==== dv/scie_irq_assertions.sv ====
// Checker for the card port interrupt enable logic.
`timescale 1ns/1ns
module scie_chk (
  // Clock and controls.
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] irq_enable,
  input wire logic [1:0] rx_trigger_level,
  input wire logic [3:0] flag_clear,
  // Sources.
  input wire scie_pkg::scie_events_t events,
  input wire scie_pkg::scie_errors_t errors,
  // Outputs.
  input wire logic [31:0] card_port_status_reg,
  input wire logic [3:0] irq_flags,
  input wire logic rx_timeout_flag,
  input wire logic irq
);
  import scie_pkg::*;
  // Level reached and status word expected from this cycle's inputs.
  wire logic lvl_hit = events.rx_count >= ((rx_trigger_level == 2'h3) ?
    3'h1 : {1'h0, rx_trigger_level} + 3'h1);
  wire logic [31:0] st_exp = {1'h0, errors[0], 7'h00, errors[1],
    13'h0000, errors[2], 1'h0, errors[6:4], 3'h0, errors[3]};
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Each output follows its cause at the previous edges.
  tmr_set_a: assert property (
    clk_en && events.timer0_event |=> irq_flags[3])
    else $error("timer flag missed");
  terr_set_a: assert property (
    clk_en && |errors |=> irq_flags[2])
    else $error("error flag missed");
  txe_trk_a: assert property (
    clk_en |=> irq_flags[1] == $past(events.tx_empty))
    else $error("tx empty flag wrong");
  lvl_trk_a: assert property (
    clk_en |=> irq_flags[0] == $past(lvl_hit))
    else $error("rx level flag wrong");
  irq_or_a: assert property (clk_en[*3] |-> irq ==
    |($past(irq_flags) & $past(irq_enable, 2))) else $error("irq wrong");
  tmr_clr_a: assert property (clk_en && flag_clear[3] &&
    !events.timer0_event |=> !irq_flags[3]) else $error("clear lost");
  st_map_a: assert property (
    clk_en |=> card_port_status_reg == $past(st_exp))
    else $error("status word wrong");
  tmo_clr_a: assert property (clk_en && events.rx_count == 3'h0
    |=> !rx_timeout_flag) else $error("timeout flag stuck");
  tmo_set_a: assert property (
    clk_en && events.rx_timeout_event && events.rx_count != 3'h0
    |=> rx_timeout_flag) else $error("timeout flag missed");
endmodule : scie_chk

// ==== dv/scie_irq_test.sv ====
// Self-checking bench for the card port interrupt enable logic.
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module scie_irq_test;
  import scie_pkg::*;
  logic clock = 1'h0, resetn = 1'h0, clk_en = 1'h1, slow = 1'h0;
  logic [3:0] irq_enable = 4'h0, flag_clear, irq_flags;
  logic [3:0] m_fl = 4'h2, m_en = 4'h0;
  logic [1:0] rx_trigger_level = 2'h0;
  logic [31:0] card_port_status_reg, r, m_st = 32'h0000_0000;
  logic rx_timeout_flag, irq, m_irq = 1'h0, m_to = 1'h0;
  scie_events_t events = '0;
  scie_errors_t errors = '0;
  int failures = 0, samples_checked = 0;
  scie_irq dut_u (
    .clock(clock), .resetn(resetn), .clk_en(clk_en),
    .irq_enable(irq_enable), .rx_trigger_level(rx_trigger_level),
    .flag_clear(flag_clear), .events(events), .errors(errors),
    .card_port_status_reg(card_port_status_reg), .irq_flags(irq_flags),
    .rx_timeout_flag(rx_timeout_flag), .irq(irq)
  );
  scie_sw_model sw_u (
    .clock(clock), .slow(slow), .irq(irq), .irq_flags(irq_flags),
    .flag_clear(flag_clear)
  );
  // Clock of 10 ns period.
  always #5 clock = ~clock;
  // Status word position of each error flag.
  function automatic logic [31:0] smap(scie_errors_t e);
    return {1'h0, e[0], 7'h00, e[1], 13'h0000, e[2], 1'h0, e[6:4],
      3'h0, e[3]};
  endfunction : smap
  // Receive count reaches the trigger level.
  function automatic logic hit(logic [2:0] n, logic [1:0] t);
    return n >= ((t == 2'h3) ? 3'h1 : {1'h0, t} + 3'h1);
  endfunction : hit
  task test_done;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Watchdog far beyond the 300 cycles of stimulus.
  initial begin
    #20000;
    failures++;
    test_done();
  end
  // Single errors first, then random traffic checked against a model.
  initial begin
    void'($urandom(32'h2EF22542));
    repeat (4) @(posedge clock);
    #1 resetn = 1'h1;
    for (int k = 0; k < 300; k++) begin
      @(posedge clock);
      // The model only moves on edges at which the design is enabled.
      if (clk_en) begin
        m_irq = |(m_fl & m_en);
        m_en = irq_enable;
        m_fl = {events.timer0_event | m_fl[3] & ~flag_clear[3],
          |errors | m_fl[2] & ~flag_clear[2],
          events.tx_empty,
          hit(events.rx_count, rx_trigger_level)};
        m_st = smap(errors);
        if (events.rx_count == 3'h0) m_to = 1'h0;
        else if (events.rx_timeout_event) m_to = 1'h1;
      end
      #1;
      `CHK("flags", m_fl, irq_flags)
      `CHK("irq", m_irq, irq)
      `CHK("status", m_st, card_port_status_reg)
      `CHK("timeout", m_to, rx_timeout_flag)
      r = $urandom;
      events = {r[6:3], (r[2:0] > 3'h4) ? 3'h4 : r[2:0]};
      errors = (k < 7) ? 7'h40 >> k : (r[31:29] == 3'h0) ? r[13:7] :
        7'h00;
      irq_enable = r[17:14];
      rx_trigger_level = r[19:18];
      slow = r[20];
      clk_en = (k < 7) | r[21] | r[22];
    end
    // An asynchronous reset in mid-traffic must restore every output.
    resetn = 1'h0;
    #1;
    `CHK("reset flags", 4'h2, irq_flags)
    `CHK("reset irq", 1'h0, irq)
    `CHK("reset status", 32'h0000_0000, card_port_status_reg)
    `CHK("reset timeout", 1'h0, rx_timeout_flag)
    test_done();
  end
endmodule : scie_irq_test
bind scie_irq scie_chk chk_u (.clock(clock), .resetn(resetn),
  .clk_en(clk_en), .irq_enable(irq_enable),
  .rx_trigger_level(rx_trigger_level), .flag_clear(flag_clear),
  .events(events), .errors(errors),
  .card_port_status_reg(card_port_status_reg), .irq_flags(irq_flags),
  .rx_timeout_flag(rx_timeout_flag), .irq(irq));
